// [core/cce_pkg.sv]
// Constants for the call/clear/complement/watchdog execution block
package cce_pkg;
   localparam int PC_W          = 13;
   localparam int LIT_W         = 11;
   localparam int OPC_W         = 14;
   localparam int FADDR_W       = 7;
   localparam int DATA_W        = 8;
   localparam int PAGE_HI_BIT   = 4;
   localparam int PAGE_LO_BIT   = 3;
   localparam int CALL_CYCLES   = 2;
   // Opcode patterns
   localparam logic [2:0]  OPC_CALL_PFX  = 3'h4;
   localparam logic [6:0]  OPC_ZFILE_PFX = 7'h03;
   localparam logic [13:0] OPC_ZACC      = 14'h0103;
   localparam logic [13:0] OPC_WDKICK    = 14'h0064;
   localparam logic [5:0]  OPC_INV_PFX   = 6'h09;
   // Reset values
   localparam logic [12:0] PC_RST        = 13'h0000;
   localparam logic [7:0]  ACC_RST       = 8'h00;
   localparam logic [7:0]  WDOG_RST      = 8'h00;
   localparam logic [7:0]  PRESC_RST     = 8'h00;
   typedef enum logic [1:0] {ST_EXEC, ST_CALL2} cce_state_t;
endpackage

// [core/cce_exec.sv]
// Execution unit for subroutine call, clears, complement and watchdog kick
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps

module cce_exec
   import cce_pkg::*;
#(
   parameter int WDOG_W  = 8,
   parameter int PRESC_W = 8
)(
   input  wire logic                core_clk,           // Core clock
   input  wire logic                sys_rst,            // Async reset, active high
   input  wire logic                instrValid,         // Fetched opcode is present
   input  wire logic [OPC_W-1:0]    opcode,             // Fetched opcode
   input  wire logic [DATA_W-1:0]   fileRdData,         // Addressed file register value
   input  wire logic [DATA_W-1:0]   programPageLatch,   // Page latch register
   input  wire logic                wdogTick,           // Watchdog count enable
   input  wire logic                presTick,           // Prescaler count enable
   input  wire logic                sleepEnter,         // Sleep entry clears power-down bit
   input  wire logic                wdogTimeout,        // Time-out event clears time-out bit
   output logic [FADDR_W-1:0]       fileAddr,           // File register address
   output logic                     fileWrEn,           // File register write strobe
   output logic [DATA_W-1:0]        fileWrData,         // File register write data
   output logic                     stackPush,          // Return stack push strobe
   output logic [PC_W-1:0]          returnStackTop,     // Value pushed onto stack
   output logic [PC_W-1:0]          programCounter,     // Program counter
   output logic [DATA_W-1:0]        accum,              // Working accumulator
   output logic                     zeroFlag,           // Zero flag
   output logic                     timeoutStatusN,     // Time-out status, active low
   output logic                     powerdownStatusN,   // Power-down status, active low
   output logic [WDOG_W-1:0]        watchdogCounter,    // Watchdog counter
   output logic [PRESC_W-1:0]       wdogPrescaler,      // Watchdog prescaler
   output logic                     busy                // Second cycle of a call
);

   // ==========================================
   // Decode
   logic       isCall;
   logic       isZFile;
   logic       isZAcc;
   logic       isWdKick;
   logic       isInv;
   logic       destFile;
   logic       execCycle;
   logic [DATA_W-1:0] invResult;
   cce_state_t state_r;

   assign execCycle = instrValid && (state_r == ST_EXEC);
   assign isCall    = execCycle && (opcode[13:11] == OPC_CALL_PFX);
   assign isZFile   = execCycle && (opcode[13:7] == OPC_ZFILE_PFX);
   assign isZAcc    = execCycle && (opcode == OPC_ZACC);
   assign isWdKick  = execCycle && (opcode == OPC_WDKICK);
   assign isInv     = execCycle && (opcode[13:8] == OPC_INV_PFX);
   assign destFile  = opcode[7];
   assign invResult = ~fileRdData;
   assign busy      = (state_r == ST_CALL2);

   // ==========================================
   // Call sequencing
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_EXEC;
      end else begin
         case (state_r)
            ST_EXEC: begin
               if (isCall) begin
                  state_r <= ST_CALL2;
               end
            end
            ST_CALL2: state_r <= ST_EXEC;
            default:  state_r <= ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         programCounter <= PC_RST;
      end else if (isCall) begin
         programCounter <= {programPageLatch[PAGE_HI_BIT:PAGE_LO_BIT],
                            opcode[LIT_W-1:0]};
      end else if (execCycle) begin
         programCounter <= programCounter + 13'h0001;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stackPush      <= 1'b0;
         returnStackTop <= PC_RST;
      end else begin
         stackPush <= isCall;
         if (isCall) begin
            returnStackTop <= programCounter + 13'h0001;
         end
      end
   end

   // ==========================================
   // File register write path
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fileWrEn   <= 1'b0;
         fileWrData <= ACC_RST;
      end else begin
         fileWrEn <= isZFile || (isInv && destFile);
         if (isZFile) begin
            fileWrData <= ACC_RST;
         end else if (isInv) begin
            fileWrData <= invResult;
         end
      end
   end

   assign fileAddr = opcode[FADDR_W-1:0];

   // ==========================================
   // Accumulator and zero flag
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         accum <= ACC_RST;
      end else if (isZAcc) begin
         accum <= ACC_RST;
      end else if (isInv && !destFile) begin
         accum <= invResult;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         zeroFlag <= 1'b0;
      end else if (isZFile || isZAcc) begin
         zeroFlag <= 1'b1;
      end else if (isInv) begin
         zeroFlag <= (invResult == ACC_RST);
      end
   end

   // ==========================================
   // Watchdog counter, prescaler and status bits
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdogPrescaler   <= PRESC_W'(PRESC_RST);
         watchdogCounter <= WDOG_W'(WDOG_RST);
      end else if (isWdKick) begin
         wdogPrescaler   <= PRESC_W'(PRESC_RST);
         watchdogCounter <= WDOG_W'(WDOG_RST);
      end else begin
         if (presTick) begin
            wdogPrescaler <= wdogPrescaler + PRESC_W'(1);
         end
         if (wdogTick) begin
            watchdogCounter <= watchdogCounter + WDOG_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timeoutStatusN   <= 1'b1;
         powerdownStatusN <= 1'b1;
      end else if (isWdKick) begin
         timeoutStatusN   <= 1'b1;
         powerdownStatusN <= 1'b1;
      end else begin
         if (wdogTimeout) begin
            timeoutStatusN <= 1'b0;
         end
         if (sleepEnter) begin
            powerdownStatusN <= 1'b0;
         end
      end
   end

endmodule

// [tb/cce_exec_checker.sv]
// Assertion checker for the execution block
`timescale 1ns/1ps
module cce_exec_checker
   import cce_pkg::*;
#(parameter int WDOG_W = 8, parameter int PRESC_W = 8)(
   input wire logic                 core_clk, sys_rst,                   // Clock, reset
   input wire logic                 instrValid, busy, stackPush,         // Control
   input wire logic                 fileWrEn, zeroFlag,                  // Write, flag
   input wire logic [OPC_W-1:0]     opcode,                              // Opcode
   input wire logic [PC_W-1:0]      returnStackTop, programCounter,      // Counter
   input wire logic [DATA_W-1:0]    programPageLatch, fileRdData,        // Inputs
   input wire logic [DATA_W-1:0]    fileWrData, accum,                   // Results
   input wire logic                 timeoutStatusN, powerdownStatusN,    // Status
   input wire logic [WDOG_W-1:0]    watchdogCounter,                     // Watchdog
   input wire logic [PRESC_W-1:0]   wdogPrescaler                        // Prescaler
);
   logic take;
   assign take = instrValid && !busy;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence callTaken; take && opcode[13:11] == OPC_CALL_PFX; endsequence
   sequence invTaken(bit d); take && opcode[13:8] == OPC_INV_PFX && opcode[7] == d; endsequence
   sequence kickTaken; take && opcode == OPC_WDKICK; endsequence
   call_push_a: assert property (callTaken |=> stackPush && returnStackTop == $past(programCounter) + 13'h1)
      else $error("call pushed wrong return address");
   call_target_a: assert property (callTaken |=> programCounter == {$past(programPageLatch[4:3]), $past(opcode[10:0])})
      else $error("call loaded wrong target");
   call_flags_a: assert property (callTaken |=> busy && $stable(zeroFlag) ##1 !busy)
      else $error("call length or flag wrong");
   zero_file_a: assert property (take && opcode[13:7] == OPC_ZFILE_PFX |=> fileWrEn && fileWrData == 8'h00 && zeroFlag)
      else $error("file clear wrong");
   zero_accum_a: assert property (take && opcode == OPC_ZACC |=> accum == 8'h00 && zeroFlag && !fileWrEn)
      else $error("accumulator clear wrong");
   kick_count_a: assert property (kickTaken |=> watchdogCounter == '0 && wdogPrescaler == '0)
      else $error("watchdog not cleared");
   kick_status_a: assert property (kickTaken |=> timeoutStatusN && powerdownStatusN)
      else $error("status bits not set");
   inv_file_a: assert property (invTaken(1) |=> fileWrEn && fileWrData == ~$past(fileRdData) && zeroFlag == (fileWrData == 8'h00))
      else $error("complement to file wrong");
   inv_accum_a: assert property (invTaken(0) |=> !fileWrEn && accum == ~$past(fileRdData))
      else $error("complement to accumulator wrong");
endmodule
bind cce_exec cce_exec_checker #(.WDOG_W(WDOG_W), .PRESC_W(PRESC_W)) u_chk (.*);

// [tb/cce_regfile_model.sv]
// Behavioural data register file facing the execution block
`timescale 1ns/1ps
module cce_regfile_model
   import cce_pkg::*;
(
   input  wire logic               core_clk,     // Core clock
   input  wire logic [FADDR_W-1:0] fileAddr,     // Register index
   input  wire logic               fileWrEn,     // Write strobe
   input  wire logic [DATA_W-1:0]  fileWrData,   // Write data
   output logic      [DATA_W-1:0]  fileRdData    // Read data
);
   logic [DATA_W-1:0] mem [128];
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5A;
   end
   assign fileRdData = mem[fileAddr];
   always @(posedge core_clk) begin
      if (fileWrEn) mem[fileAddr] <= fileWrData;
   end
endmodule

// [tb/cce_exec_tb.sv]
// Self-checking bench for the execution block
`timescale 1ns/1ps
module cce_exec_tb;
   import cce_pkg::*;
   logic core_clk = 0, sys_rst = 1, instrValid = 0, wdogTick = 0, presTick = 0, sleepEnter = 0, wdogTimeout = 0;
   logic [OPC_W-1:0] opcode = '0;
   logic [DATA_W-1:0] programPageLatch = '0, fileRdData, fileWrData, accum;
   logic [FADDR_W-1:0] fileAddr;
   logic [PC_W-1:0] returnStackTop, programCounter;
   logic fileWrEn, stackPush, zeroFlag, timeoutStatusN, powerdownStatusN, busy;
   logic [7:0] watchdogCounter, wdogPrescaler;
   int err_count = 0, checks_done = 0;
   always #12.5 core_clk = ~core_clk;
   cce_exec u_dut (.*);
   cce_regfile_model u_mem (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic issue(input logic [OPC_W-1:0] op);
      @(posedge core_clk);
      instrValid <= 1'b1;
      opcode <= op;
      @(posedge core_clk);
      instrValid <= 1'b0;
      #1;
   endtask
   task automatic t_call(input logic [7:0] page, input logic [10:0] k);
      logic [PC_W-1:0] pc;
      logic z;
      programPageLatch <= page;
      pc = programCounter;
      z = zeroFlag;
      issue({OPC_CALL_PFX, k});
      chk({stackPush, returnStackTop}, {1'b1, pc + 13'h1});
      chk(programCounter, {page[4:3], k});
      chk({busy, zeroFlag}, {1'b1, z});
   endtask
   task automatic t_file;
      issue({OPC_ZFILE_PFX, 7'h05});
      chk({fileWrEn, fileWrData, zeroFlag}, {1'b1, 8'h00, 1'b1});
      chk(fileAddr, 7'h05);
      chk(programCounter, 13'h1556);
      issue({OPC_INV_PFX, 1'b1, 7'h05});
      chk({fileWrEn, fileWrData, zeroFlag}, {1'b1, 8'hFF, 1'b0});
      issue({OPC_INV_PFX, 1'b0, 7'h05});
      chk({fileWrEn, accum, zeroFlag}, {1'b0, 8'h00, 1'b1});
      issue({OPC_INV_PFX, 1'b0, 7'h12});
      chk({accum, zeroFlag}, {~(8'h12 ^ 8'h5A), 1'b0});
      issue(OPC_ZACC);
      chk({fileWrEn, accum, zeroFlag}, {1'b0, 8'h00, 1'b1});
   endtask
   task automatic t_wdog;
      @(posedge core_clk);
      {wdogTick, presTick, sleepEnter, wdogTimeout} <= 4'hF;
      repeat (3) @(posedge core_clk);
      {wdogTick, presTick, sleepEnter, wdogTimeout} <= 4'h0;
      #1;
      chk({timeoutStatusN, powerdownStatusN, watchdogCounter != 0}, 3'h1);
      chk({watchdogCounter, wdogPrescaler}, 16'h0303);
      issue(OPC_WDKICK);
      chk({watchdogCounter, wdogPrescaler}, 16'h0000);
      chk({timeoutStatusN, powerdownStatusN}, 2'h3);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_call(8'h18, 11'h7FF);
      t_call(8'h08, 11'h000);
      t_call(8'h10, 11'h555);
      t_file;
      t_wdog;
      conclude;
   end
   initial begin
      #(25 * 2000);
      err_count++;
      conclude;
   end
endmodule
